/* hdl/sysctl_pkg.sv */
// Constants, register map and state types for the system control block.
// Assumes a plain single-cycle register port and one clock domain.
package sysctl_pkg;

  // ==========================================================
  // Sizes
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int NUM_EXT    = 9;
  localparam int NUM_LINES  = 4;
  localparam int NUM_CAP    = 8;
  localparam int NUM_PERIPH = 16;
  localparam int WAKE_CLKS  = 1024;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_MEMMAP   = 8'h04;
  localparam logic [7:0] OFF_PERIPH   = 8'h08;
  localparam logic [7:0] OFF_DIV      = 8'h0c;
  localparam logic [7:0] OFF_EXT_MODE = 8'h10;
  localparam logic [7:0] OFF_EXT_POL  = 8'h14;
  localparam logic [7:0] OFF_EXT_FLAG = 8'h18;
  localparam logic [7:0] OFF_EXT_WAKE = 8'h1c;
  localparam logic [7:0] OFF_RTC_SRC  = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_STATE    = 8'h2c;

  // ==========================================================
  // Field positions
  localparam int MODE_IDLE_BIT = 0;
  localparam int MODE_PD_BIT   = 1;
  localparam int IRQ_IDLE_EXIT = 0;
  localparam int IRQ_PD_WAKE   = 1;
  localparam int IRQ_EXT       = 2;
  localparam int IRQ_W         = 3;

  // ==========================================================
  // Divider ratio codes and reset values
  localparam logic [1:0] DIV_QUARTER = 2'h0;
  localparam logic [1:0] DIV_FULL    = 2'h1;
  localparam logic [1:0] DIV_HALF    = 2'h2;
  localparam logic [1:0] RST_DIV     = DIV_QUARTER;
  localparam logic [1:0] RST_MODE    = 2'h0;
  localparam logic       RST_MEMMAP  = 1'b0;
  localparam logic       RST_RTC_SRC = 1'b0;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PDOWN = 2'b10,
    ST_WAKE  = 2'b11
  } pwr_state_t;

endpackage

/* hdl/sysctl_link_if.sv */
// Signals shared between the control top and its two helper units.
// Assumes both helpers run on the control clock.
`timescale 1ns/1ps
interface sysctl_link_if #(
  parameter int NUM_EXT   = 9,
  parameter int NUM_LINES = 4
);
  // ==========================================================
  // Divider group
  logic                 div_ce;
  logic [1:0]           div_sel;
  logic                 pclk_tick;
  logic [1:0]           div_active;
  // ==========================================================
  // External interrupt group
  logic                 eint_ce;
  logic [NUM_EXT-1:0]   ext_pin;
  logic [NUM_EXT-1:0]   edge_mode;
  logic [NUM_EXT-1:0]   act_high;
  logic [NUM_EXT-1:0]   flag_clr;
  logic [NUM_EXT-1:0]   flag;
  logic [NUM_LINES-1:0] wake_en;
  logic [NUM_LINES-1:0] line_irq;
  logic                 wake_req;

  modport div_mp (input div_ce, div_sel, output pclk_tick, div_active);
  modport eint_mp (input eint_ce, ext_pin, edge_mode, act_high, flag_clr, wake_en,
                   output flag, line_irq, wake_req);
endinterface

/* hdl/pbus_divider.sv */
// Peripheral bus clock divider: makes a one-cycle enable at 1/1, 1/2 or 1/4.
// Assumes the processor clock is the only clock; the enable qualifies it.
`timescale 1ns/1ps
module pbus_divider
  import sysctl_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   sys_rst_i,
  sysctl_link_if.div_mp lk
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] sel_reg;
  logic [1:0] sel_next;
  logic [1:0] limit;
  logic       wrap;

  // ==========================================================
  // Count and ratio update
  // A new ratio is only taken at the wrap so no shortened period appears
  always_comb begin
    unique case (sel_reg)
      DIV_FULL: limit = 2'h0;
      DIV_HALF: limit = 2'h1;
      default:  limit = 2'h3;
    endcase
    wrap     = (cnt_reg == limit);
    cnt_next = cnt_reg;
    sel_next = sel_reg;
    if (lk.div_ce) begin
      if (wrap) begin
        cnt_next = 2'h0;
        sel_next = lk.div_sel;
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= 2'h0;
      sel_reg <= RST_DIV;
    end else begin
      cnt_reg <= cnt_next;
      sel_reg <= sel_next;
    end
  end

  assign lk.pclk_tick  = lk.div_ce & wrap;
  assign lk.div_active = sel_reg;

endmodule

/* hdl/ext_int_unit.sv */
// External interrupt detection: per-pin edge or level, merged onto lines.
// Assumes pins are synchronous to the clock; wake path needs no clock edge.
`timescale 1ns/1ps
module ext_int_unit
  import sysctl_pkg::*;
#(
  parameter int NUM_EXT   = 9,
  parameter int NUM_LINES = 4
)(
  input  wire logic      clk_i,
  input  wire logic      sys_rst_i,
  sysctl_link_if.eint_mp lk
);

  logic [NUM_EXT-1:0]   act;
  logic [NUM_EXT-1:0]   prev_reg;
  logic [NUM_EXT-1:0]   prev_next;
  logic [NUM_EXT-1:0]   flag_reg;
  logic [NUM_EXT-1:0]   flag_next;
  logic [NUM_LINES-1:0] wake_line;

  if (NUM_LINES < 1 || NUM_EXT < NUM_LINES) begin : g_bad
    $error("ext_int_unit: need 1 <= NUM_LINES <= NUM_EXT");
  end

  // ==========================================================
  // Detection: edges are sticky, levels follow the pin
  always_comb begin
    act       = ~(lk.ext_pin ^ lk.act_high);
    prev_next = lk.eint_ce ? act : prev_reg;
    flag_next = flag_reg;
    if (lk.eint_ce) begin
      for (int k = 0; k < NUM_EXT; k++) begin
        if (lk.edge_mode[k])                       // Set beats clear
          flag_next[k] = (flag_reg[k] & ~lk.flag_clr[k]) | (act[k] & ~prev_reg[k]);
        else
          flag_next[k] = act[k];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      prev_reg <= '0;
      flag_reg <= '0;
    end else begin
      prev_reg <= prev_next;
      flag_reg <= flag_next;
    end
  end

  // ==========================================================
  // Merge pin k onto line k mod NUM_LINES
  for (genvar l = 0; l < NUM_LINES; l++) begin : g_line
    logic [NUM_EXT-1:0] sel;
    always_comb begin
      sel = '0;
      for (int k = l; k < NUM_EXT; k += NUM_LINES) sel[k] = 1'b1;
    end
    assign lk.line_irq[l] = |(flag_reg & sel);
    // Raw pin level joins in so wake works with the clock stopped
    assign wake_line[l] = lk.wake_en[l] & |((act | flag_reg) & sel);
  end

  assign lk.flag     = flag_reg;
  assign lk.wake_req = |wake_line;

endmodule

/* hdl/system_power_clock_control.sv */
// System power and clock control: external interrupts, vector mapping,
// idle and power-down sequencing, peripheral switches, peripheral divider.
// Assumes one processor clock, synchronous pins, single-cycle register port.
//
// What this block does
// - Nine external inputs merged onto four lines
// - Enabled external inputs wake from power-down clocklessly
// - Capture interrupts never wake from power-down
// - Vector area mapped to flash or SRAM
// - Idle stops processor until reset or interrupt
// - Peripheral clocks keep running in idle
// - Power-down stops oscillator and all clocks
// - Power-down keeps state and holds output pins
// - Power-down exits only on reset or wake
// - RTC runs in power-down only on external clock
// - Each peripheral has its own clock switch
// - Peripheral clock is full, half or quarter
// - Divider resets to one quarter
// - PLL stays active in idle if running
// - Power-down exit passes through wake-up timer
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module system_power_clock_control
  import sysctl_pkg::*;
#(
  parameter int NUM_PERIPH_P = NUM_PERIPH,
  parameter int NUM_CAP_P    = NUM_CAP,
  parameter int WAKE_CLKS_P  = WAKE_CLKS
)(
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [DATA_W-1:0]       wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [DATA_W-1:0]       rdata_o,
  input  wire logic [NUM_EXT-1:0]      ext_pin_i,
  input  wire logic [NUM_CAP_P-1:0]    cap_pin_i,
  input  wire logic                    cpu_irq_i,
  input  wire logic                    osc_ready_i,
  input  wire logic                    pll_running_i,
  output logic      [NUM_LINES-1:0]    eint_o,
  output logic      [NUM_CAP_P-1:0]    cap_irq_o,
  output logic                         cpu_run_o,
  output logic                         cpu_clk_en_o,
  output logic                         pclk_en_o,
  output logic      [NUM_PERIPH_P-1:0] periph_clk_en_o,
  output logic                         vector_sram_o,
  output logic                         osc_en_o,
  output logic                         pll_keep_o,
  output logic                         pin_hold_o,
  output logic                         rtc_clk_en_o,
  output logic      [1:0]              pwr_state_o,
  output logic                         irq_o
);

  if (NUM_PERIPH_P < 1 || NUM_PERIPH_P > DATA_W || NUM_CAP_P < 1 || NUM_CAP_P > DATA_W
      || WAKE_CLKS_P < 1 || WAKE_CLKS_P > 65535) begin : g_bad
    $error("system_power_clock_control: parameter out of range");
  end

  sysctl_link_if #(.NUM_EXT(NUM_EXT), .NUM_LINES(NUM_LINES)) lk ();

  // ==========================================================
  // Registers
  pwr_state_t              state_reg;
  pwr_state_t              state_next;
  logic [15:0]             wcnt_reg;
  logic [15:0]             wcnt_next;
  logic [1:0]              mode_reg;
  logic [1:0]              mode_next;
  logic                    memmap_reg;
  logic                    memmap_next;
  logic [NUM_PERIPH_P-1:0] periph_reg;
  logic [NUM_PERIPH_P-1:0] periph_next;
  logic [1:0]              div_reg;
  logic [1:0]              div_next;
  logic [NUM_EXT-1:0]      emode_reg;
  logic [NUM_EXT-1:0]      emode_next;
  logic [NUM_EXT-1:0]      epol_reg;
  logic [NUM_EXT-1:0]      epol_next;
  logic [NUM_LINES-1:0]    ewake_reg;
  logic [NUM_LINES-1:0]    ewake_next;
  logic                    rtc_src_reg;
  logic                    rtc_src_next;
  logic [IRQ_W-1:0]        stat_reg;
  logic [IRQ_W-1:0]        stat_next;
  logic [IRQ_W-1:0]        mask_reg;
  logic [IRQ_W-1:0]        mask_next;
  logic [NUM_CAP_P-1:0]    cap_reg;
  logic [NUM_CAP_P-1:0]    cap_next;
  logic [NUM_LINES-1:0]    line_prev_reg;
  logic [NUM_LINES-1:0]    line_prev_next;
  logic [DATA_W-1:0]       rdata_reg;
  logic [DATA_W-1:0]       rdata_next;

  logic                    idle_exit;
  logic                    pd_wake_done;
  logic                    wake_hit;
  logic [IRQ_W-1:0]        events;
  logic                    clocks_on;

  // ==========================================================
  // Helper connections
  assign clocks_on    = (state_reg == ST_RUN) || (state_reg == ST_IDLE);
  assign lk.div_ce    = ce_i & clocks_on;
  assign lk.div_sel   = div_reg;
  assign lk.eint_ce   = ce_i & clocks_on;
  assign lk.ext_pin   = ext_pin_i;
  assign lk.edge_mode = emode_reg;
  assign lk.act_high  = epol_reg;
  assign lk.wake_en   = ewake_reg;
  assign lk.flag_clr  = (wr_i && addr_i == OFF_EXT_FLAG) ? wdata_i[NUM_EXT-1:0]
                                                         : '0;

  pbus_divider u_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .lk        (lk.div_mp)
  );

  ext_int_unit #(
    .NUM_EXT   (NUM_EXT),
    .NUM_LINES (NUM_LINES)
  ) u_eint (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .lk        (lk.eint_mp)
  );

  // ==========================================================
  // Power state sequencing
  // Capture inputs are left out of wake_hit on purpose
  assign wake_hit  = lk.wake_req;
  assign idle_exit = (state_reg == ST_IDLE) &&
                     (cpu_irq_i || (|lk.line_irq) || (|cap_reg));

  always_comb begin
    state_next   = state_reg;
    wcnt_next    = wcnt_reg;
    pd_wake_done = 1'b0;
    if (ce_i) begin
      unique case (state_reg)
        ST_RUN: begin
          if (mode_reg[MODE_PD_BIT])               // Power-down outranks idle
            state_next = ST_PDOWN;
          else if (mode_reg[MODE_IDLE_BIT])
            state_next = ST_IDLE;
        end
        ST_IDLE: begin
          if (idle_exit)
            state_next = ST_RUN;
        end
        ST_PDOWN: begin
          wcnt_next = 16'h0;
          if (wake_hit)
            state_next = ST_WAKE;
        end
        ST_WAKE: begin
          // Count only once the oscillator reports good amplitude
          if (osc_ready_i) begin
            if (wcnt_reg == 16'(WAKE_CLKS_P - 1)) begin
              state_next   = ST_RUN;
              pd_wake_done = 1'b1;
            end else begin
              wcnt_next = wcnt_reg + 16'h1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_RUN;
      wcnt_reg  <= 16'h0;
    end else begin
      state_reg <= state_next;
      wcnt_reg  <= wcnt_next;
    end
  end

  // ==========================================================
  // Software registers; writes override hardware clears
  always_comb begin
    mode_next    = mode_reg;
    memmap_next  = memmap_reg;
    periph_next  = periph_reg;
    div_next     = div_reg;
    emode_next   = emode_reg;
    epol_next    = epol_reg;
    ewake_next   = ewake_reg;
    rtc_src_next = rtc_src_reg;
    mask_next    = mask_reg;
    if (ce_i) begin
      if (idle_exit)
        mode_next[MODE_IDLE_BIT] = 1'b0;
      if (pd_wake_done)
        mode_next[MODE_PD_BIT] = 1'b0;
      if (wr_i) begin
        unique case (addr_i)
          OFF_MODE:     mode_next    = wdata_i[1:0];
          OFF_MEMMAP:   memmap_next  = wdata_i[0];
          OFF_PERIPH:   periph_next  = wdata_i[NUM_PERIPH_P-1:0];
          OFF_DIV:      div_next     = wdata_i[1:0];
          OFF_EXT_MODE: emode_next   = wdata_i[NUM_EXT-1:0];
          OFF_EXT_POL:  epol_next    = wdata_i[NUM_EXT-1:0];
          OFF_EXT_WAKE: ewake_next   = wdata_i[NUM_LINES-1:0];
          OFF_RTC_SRC:  rtc_src_next = wdata_i[0];
          OFF_IRQ_MASK: mask_next    = wdata_i[IRQ_W-1:0];
          default:      ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_reg    <= RST_MODE;
      memmap_reg  <= RST_MEMMAP;
      periph_reg  <= '1;
      div_reg     <= RST_DIV;
      emode_reg   <= '0;
      epol_reg    <= '0;
      ewake_reg   <= '0;
      rtc_src_reg <= RST_RTC_SRC;
      mask_reg    <= '0;
    end else begin
      mode_reg    <= mode_next;
      memmap_reg  <= memmap_next;
      periph_reg  <= periph_next;
      div_reg     <= div_next;
      emode_reg   <= emode_next;
      epol_reg    <= epol_next;
      ewake_reg   <= ewake_next;
      rtc_src_reg <= rtc_src_next;
      mask_reg    <= mask_next;
    end
  end

  // ==========================================================
  // Interrupt status: sticky, write one to clear, set wins
  always_comb begin
    events                = '0;
    events[IRQ_IDLE_EXIT] = idle_exit;
    events[IRQ_PD_WAKE]   = pd_wake_done;
    events[IRQ_EXT]       = |(lk.line_irq & ~line_prev_reg);
    stat_next             = stat_reg;
    line_prev_next        = line_prev_reg;
    cap_next              = cap_reg;
    if (ce_i) begin
      if (wr_i && addr_i == OFF_IRQ_STAT)
        stat_next = stat_next & ~wdata_i[IRQ_W-1:0];
      stat_next      = stat_next | events;
      line_prev_next = lk.line_irq;
      // Capture interrupts are frozen with the peripherals in power-down
      if (clocks_on)
        cap_next = cap_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_reg      <= '0;
      line_prev_reg <= '0;
      cap_reg       <= '0;
    end else begin
      stat_reg      <= stat_next;
      line_prev_reg <= line_prev_next;
      cap_reg       <= cap_next;
    end
  end

  // ==========================================================
  // Read port: data stands in the cycle after the strobe, and holds while ce_i is low
  always_comb begin
    rdata_next = '0;
    if (ce_i && rd_i) begin
      unique case (addr_i)
        OFF_MODE:     rdata_next[1:0]              = mode_reg;
        OFF_MEMMAP:   rdata_next[0]                = memmap_reg;
        OFF_PERIPH:   rdata_next[NUM_PERIPH_P-1:0] = periph_reg;
        OFF_DIV:      rdata_next[1:0]              = div_reg;
        OFF_EXT_MODE: rdata_next[NUM_EXT-1:0]      = emode_reg;
        OFF_EXT_POL:  rdata_next[NUM_EXT-1:0]      = epol_reg;
        OFF_EXT_FLAG: rdata_next[NUM_EXT-1:0]      = lk.flag;
        OFF_EXT_WAKE: rdata_next[NUM_LINES-1:0]    = ewake_reg;
        OFF_RTC_SRC:  rdata_next[0]                = rtc_src_reg;
        OFF_IRQ_STAT: rdata_next[IRQ_W-1:0]        = stat_reg;
        OFF_IRQ_MASK: rdata_next[IRQ_W-1:0]        = mask_reg;
        OFF_STATE:    rdata_next[3:0]              = {lk.div_active, state_reg};
        default:      rdata_next                   = '0;
      endcase
    end else if (!ce_i) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  // ==========================================================
  // Outputs decoded from registered state plus the ce_i and pll_running_i inputs
  assign rdata_o         = rdata_reg;
  assign eint_o          = lk.line_irq;
  assign cap_irq_o       = cap_reg;
  assign cpu_run_o       = (state_reg == ST_RUN);
  assign cpu_clk_en_o    = (state_reg == ST_RUN);
  // Divider ticks only in run and idle, so peripherals live through idle
  assign pclk_en_o       = lk.pclk_tick;
  assign periph_clk_en_o = {NUM_PERIPH_P{lk.pclk_tick}} & periph_reg;
  assign vector_sram_o   = memmap_reg;
  assign osc_en_o        = (state_reg != ST_PDOWN);
  assign pll_keep_o      = pll_running_i & clocks_on;
  assign pin_hold_o      = ~clocks_on;
  assign rtc_clk_en_o    = rtc_src_reg | lk.pclk_tick;
  assign pwr_state_o     = state_reg;
  assign irq_o           = |(stat_reg & mask_reg);

endmodule

/* bench/core_model.sv */
// Model of the processor core and oscillator facing the control block.
// Assumes one clock; the testbench commands interrupt requests.
`timescale 1ns/1ps
module core_model #(
  parameter int OSC_DLY = 6
)(
  input  wire logic clk_i,
  input  wire logic irq_req_i,
  input  wire logic osc_en_i,
  output logic      cpu_irq_o,
  output logic      osc_ready_o,
  output logic      pll_running_o
);
  // ==========================================================
  // Oscillator start-up and interrupt request
  logic [3:0] osc_cnt = 4'h0;

  // Ready lags the oscillator enable by a start-up delay
  always @(posedge clk_i) begin
    cpu_irq_o <= irq_req_i;
    if (osc_en_i !== 1'b1) begin
      osc_cnt <= 4'h0;
    end else if (osc_cnt != OSC_DLY[3:0]) begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end

  // PLL only runs off a running oscillator
  assign osc_ready_o   = (osc_en_i === 1'b1) && (osc_cnt == OSC_DLY[3:0]);
  assign pll_running_o = osc_ready_o;
endmodule

/* bench/sysctl_assertions.sv */
// Port-level checks of the system power and clock control block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sysctl_assertions
  import sysctl_pkg::*;
#(
  parameter int NUM_PERIPH_P = NUM_PERIPH,
  parameter int NUM_CAP_P    = NUM_CAP,
  parameter int WAKE_CLKS_P  = WAKE_CLKS
)(
  input wire logic                    clk_i,
  input wire logic                    sys_rst_i,
  input wire logic                    ce_i,
  input wire logic                    cpu_irq_i,
  input wire logic                    osc_ready_i,
  input wire logic                    pll_running_i,
  input wire logic [NUM_CAP_P-1:0]    cap_irq_o,
  input wire logic                    cpu_run_o,
  input wire logic                    cpu_clk_en_o,
  input wire logic                    pclk_en_o,
  input wire logic [NUM_PERIPH_P-1:0] periph_clk_en_o,
  input wire logic                    osc_en_o,
  input wire logic                    pll_keep_o,
  input wire logic                    pin_hold_o,
  input wire logic [1:0]              pwr_state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // Power sequencing
  chk_run_decode: assert property (cpu_run_o == (pwr_state_o == ST_RUN)
    && cpu_clk_en_o == cpu_run_o) else $error("cpu run not tied to run state");
  chk_idle_exit: assert property (pwr_state_o == ST_IDLE && ce_i && cpu_irq_i
    |=> pwr_state_o == ST_RUN) else $error("idle not left on interrupt");
  // Longest divider period is four, so four quiet idle cycles are a fault
  chk_idle_pclk: assert property (not (pwr_state_o == ST_IDLE && !pclk_en_o)[*4])
    else $error("peripheral clock stopped in idle");
  chk_pd_clocks: assert property (pwr_state_o == ST_PDOWN |-> !osc_en_o && !pclk_en_o
    && !cpu_clk_en_o && periph_clk_en_o == '0) else $error("clock alive in power-down");
  chk_pins_held: assert property (pwr_state_o[1] |-> pin_hold_o)
    else $error("pins not held");
  chk_cap_frozen: assert property (pwr_state_o == ST_PDOWN |=> $stable(cap_irq_o))
    else $error("capture state moved in power-down");
  chk_pd_exit: assert property (pwr_state_o == ST_PDOWN
    |=> pwr_state_o inside {ST_PDOWN, ST_WAKE}) else $error("power-down left wrongly");
  chk_wake_osc: assert property (pwr_state_o == ST_WAKE && !osc_ready_i
    |=> pwr_state_o == ST_WAKE) else $error("run resumed without oscillator");
  // ==========================================================
  // Clock gating and divider
  chk_periph_gate: assert property ((periph_clk_en_o & ~{NUM_PERIPH_P{pclk_en_o}}) == '0)
    else $error("peripheral enable outside tick");
  chk_div_reset: assert property ($fell(sys_rst_i) |-> (!pclk_en_o)[*3] ##1 pclk_en_o)
    else $error("first tick not at quarter rate");
  chk_pll_idle: assert property (pll_keep_o == (pll_running_i && !pwr_state_o[1]))
    else $error("pll keep wrong");

  cov_idle: cover property (pwr_state_o == ST_IDLE ##1 pwr_state_o == ST_RUN);
  cov_pdown: cover property (pwr_state_o == ST_PDOWN ##1 pwr_state_o == ST_WAKE);
  cov_wake: cover property (pwr_state_o == ST_WAKE ##1 pwr_state_o == ST_RUN);
endmodule

bind system_power_clock_control sysctl_assertions #(
  .NUM_PERIPH_P(NUM_PERIPH_P), .NUM_CAP_P(NUM_CAP_P), .WAKE_CLKS_P(WAKE_CLKS_P)
) chk_u (.clk_i, .sys_rst_i, .ce_i, .cpu_irq_i, .osc_ready_i, .pll_running_i, .cap_irq_o,
  .cpu_run_o, .cpu_clk_en_o, .pclk_en_o, .periph_clk_en_o, .osc_en_o, .pll_keep_o,
  .pin_hold_o, .pwr_state_o);

/* bench/tb_top.sv */
// Self-checking bench for the system power and clock control block.
// Assumes the core model drives interrupt and oscillator inputs.
`timescale 1ns/1ps
module tb_top
  import sysctl_pkg::*; ;
  logic        clk_i, sys_rst_i, wr_i, rd_i, irq_req, cpu_irq, osc_rdy, pll_run;
  logic        cpu_run, cpu_clk_en, pclk_en, vec_sram, osc_en, pll_keep, pin_hold, rtc_en, irq;
  logic [7:0]  addr_i, cap_pin, cap_irq;
  logic [8:0]  ext_pin;
  logic [3:0]  eint;
  logic [15:0] periph_en;
  logic [1:0]  pwr_state;
  logic [31:0] wdata_i, rdata;
  int          n_mismatch = 0;
  int          compares   = 0;
  logic [7:0]  ra [8] = '{OFF_MODE, OFF_MEMMAP, OFF_PERIPH, OFF_DIV, OFF_EXT_WAKE,
                          OFF_IRQ_MASK, OFF_STATE, 8'h3c};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [1:0]  dc [4] = '{DIV_FULL, DIV_HALF, DIV_QUARTER, 2'h3};
  int          dg [4] = '{1, 2, 4, 4};

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  system_power_clock_control #(.WAKE_CLKS_P(4)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .ext_pin_i(ext_pin), .cap_pin_i(cap_pin), .cpu_irq_i(cpu_irq), .osc_ready_i(osc_rdy),
    .pll_running_i(pll_run), .eint_o(eint), .cap_irq_o(cap_irq), .cpu_run_o(cpu_run),
    .cpu_clk_en_o(cpu_clk_en), .pclk_en_o(pclk_en), .periph_clk_en_o(periph_en),
    .vector_sram_o(vec_sram), .osc_en_o(osc_en), .pll_keep_o(pll_keep), .pin_hold_o(pin_hold),
    .rtc_clk_en_o(rtc_en), .pwr_state_o(pwr_state), .irq_o(irq));

  core_model core_u (.clk_i(clk_i), .irq_req_i(irq_req), .osc_en_i(osc_en),
    .cpu_irq_o(cpu_irq), .osc_ready_o(osc_rdy), .pll_running_o(pll_run));

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stands one cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // A hang counts as a mismatch and ends the run
  task automatic wait_st(input logic [1:0] st, input int lim);
    for (int i = 0; i < lim && pwr_state !== st; i++) tick(1);
    chk({30'h0, pwr_state}, {30'h0, st});
    if (pwr_state !== st) give_verdict();
  endtask
  // Cycles between ticks; a missing tick ends the run
  task automatic gap(input int exp);
    int n;
    for (int i = 0; i < 8 && pclk_en !== 1'b1; i++) tick(1);
    for (n = 1; n < 9; n++) begin
      tick(1);
      if (pclk_en === 1'b1) break;
    end
    chk(n, exp);
    if (n == 9) give_verdict();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    ext_pin = 9'h1ff;
    cap_pin = 8'h00;
    irq_req = 1'b0;
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    gap(4);
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_DIV, {30'h0, dc[i]});
      tick(4);
      gap(dg[i]);
    end
    wr(OFF_DIV, {30'h0, DIV_HALF});
    wr(OFF_MEMMAP, 32'h1);
    tick(1);
    chk({31'h0, vec_sram}, 32'h1);
    wr(OFF_PERIPH, 32'h5);
    tick(4);
    gap(2);
    chk({16'h0, periph_en}, 32'h5);
    // Idle entry and exit by interrupt
    wr(OFF_MODE, 32'h1);
    wait_st(ST_IDLE, 4);
    chk({29'h0, pll_keep, cpu_run, cpu_clk_en}, 32'h4);
    gap(2);
    chk({16'h0, periph_en}, 32'h5);
    @(posedge clk_i);
    irq_req <= 1'b1;
    wait_st(ST_RUN, 4);
    irq_req <= 1'b0;
    rd(OFF_MODE, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    // Level inputs: pin k lands on line k mod 4
    wr(OFF_EXT_POL, 32'h1ff);
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      ext_pin <= 9'h1 << i;
      tick(3);
      chk({28'h0, eint}, 32'h1 << (i % 4));
    end
    @(posedge clk_i);
    ext_pin <= 9'h0;
    // Edge input stays flagged after the pin drops
    wr(OFF_EXT_MODE, 32'h1);
    wr(OFF_EXT_FLAG, 32'h1ff);
    ext_pin <= 9'h1;
    @(posedge clk_i);
    ext_pin <= 9'h0;
    tick(3);
    chk({28'h0, eint}, 32'h1);
    wr(OFF_EXT_FLAG, 32'h1);
    tick(2);
    chk({28'h0, eint}, 32'h0);
    // Power-down, capture must not wake, external line 0 must
    wr(OFF_EXT_WAKE, 32'h1);
    wr(OFF_MODE, 32'h2);
    wait_st(ST_PDOWN, 4);
    chk({30'h0, osc_en, pin_hold}, 32'h1);
    cap_pin <= 8'hff;
    tick(6);
    chk({22'h0, cap_irq, pwr_state}, {30'h0, ST_PDOWN});
    wr(OFF_RTC_SRC, 32'h1);
    tick(1);
    chk({31'h0, rtc_en}, 32'h1);
    wr(OFF_RTC_SRC, 32'h0);
    tick(2);
    chk({31'h0, rtc_en}, 32'h0);
    ext_pin <= 9'h1;
    wait_st(ST_WAKE, 4);
    wait_st(ST_RUN, 40);
    ext_pin <= 9'h0;
    rd(OFF_MODE, 32'h0);
    rd(OFF_MEMMAP, 32'h1);
    rd(OFF_DIV, {30'h0, DIV_HALF});
    chk({24'h0, cap_irq}, 32'hff);
    rd(OFF_IRQ_STAT, 32'h6);
    give_verdict();
  end
endmodule
